// >>> rtl/adc_link_pkg.sv
// shared constants and types of the serial converter link
package adc_link_pkg;
  // ==========================================================
  // clocking
  localparam int unsigned CLK_KHZ = 200000;
  localparam int unsigned OSC_KHZ = 4500;
  localparam int unsigned OSC_HALF_CYC = CLK_KHZ / (2 * OSC_KHZ);
  localparam int unsigned OSC_START_NS = 100;
  localparam int unsigned OSC_START_CYC = (OSC_START_NS * CLK_KHZ + 999999) / 1000000;
  localparam int unsigned CONV_OSC_DEF = 16;
  localparam int unsigned SCLK_HALF_DEF = 13;
  localparam int unsigned REF_WAIT_MS = 10;
  localparam int unsigned REF_WAIT_CYC = REF_WAIT_MS * CLK_KHZ;
  // ==========================================================
  // control byte layout
  typedef enum logic [2:0] {
    MODE_EXT_CLK = 3'h0,
    MODE_EXT_ACQ = 3'h1,
    MODE_INT_CLK = 3'h2,
    MODE_RSVD3 = 3'h3,
    MODE_RESET = 3'h4,
    MODE_RSVD5 = 3'h5,
    MODE_PART_PD = 3'h6,
    MODE_FULL_PD = 3'h7
  } mode_t;
  localparam int unsigned START_POS = 7;
  localparam int unsigned FIELD_MSB = 6;
  localparam int unsigned FIELD_LSB = 4;
  localparam int unsigned TAIL_MSB = 3;
  localparam logic [3:0] MODE_TAIL = 4'h8;
  localparam logic [3:0] CONV_TAIL = 4'h0;
  localparam int unsigned RES_W = 16;
  // ==========================================================
  // serial clock edge numbers within a frame
  localparam logic [5:0] CMD_LAST = 6'h07;
  localparam logic [5:0] CMD_EDGES = 6'h08;
  localparam logic [5:0] EXT_SAMPLE_EDGE = 6'h0E;
  localparam logic [5:0] EXT_OUT_EDGE = 6'h10;
  localparam logic [5:0] EXT_LAST_EDGE = 6'h20;
  localparam logic [5:0] EXT_READ_FIRST = 6'h11;
  localparam logic [5:0] ACQ_SAMPLE_EDGE = 6'h10;
  localparam logic [5:0] INT_RELEASE_EDGE = 6'h08;
  localparam logic [5:0] READ_EDGES = 6'h10;
  localparam logic [5:0] READ_FIRST = 6'h01;
  localparam logic [5:0] NO_READ = 6'h3F;
  localparam logic [7:0] INT_SAMPLE_OSC = 8'h0B;
endpackage

// >>> rtl/adc_link_if.sv
// serial link between converter end and host end
interface adc_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic conversion_done_strobe;
  modport dev (input cs_n, input sclk, input din, output dout, output conversion_done_strobe);
  modport host (output cs_n, output sclk, output din, input dout, input conversion_done_strobe);
endinterface

// >>> rtl/adc_mode_ctrl.sv
// converter end: mode decoding, power states and conversion sequencing
// ==========================================================
// Overview of operation
// - decode mode field; reserved codes change nothing
// - acquisition mode samples at 16th falling edge
// - host holds select low through 16 clocks
// - host idles data and clock while converting
// - strobe rises at completion, falls at start bit
// - oscillator starts after eighth falling edge
// - internal mode samples at 11th oscillator cycle
// - host holds select low for eight clocks
// - reset code restores defaults and channel ranges
// - partial power-down keeps reference and bias
// - partial power-down left only by full byte
// - full power-down switches everything off
// - full power-down left only by full byte
// - host waits after full power-down ends
// - power-on: external clock, everything active
// - host waits for reference after power-up
// - byte: start, mode field, fixed tail
// - external clock samples at 14th falling edge
// - result MSB first on falling edges
module adc_mode_ctrl #(
  parameter int unsigned CONV_OSC = adc_link_pkg::CONV_OSC_DEF
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // serial link
  adc_link_if.dev link,
  // analog front end
  input wire logic [adc_link_pkg::RES_W-1:0] i_conv_result,
  output logic o_sample_pulse,
  output logic [2:0] o_channel,
  // power and configuration
  output logic o_analog_on,
  output logic o_ref_on,
  output logic o_cfg_default,
  output logic [2:0] o_mode
);
  // ==========================================================
  // state
  typedef enum logic [2:0] {D_IDLE, D_CMD, D_ACQ, D_OSC_WAIT, D_OSC_RUN, D_DONE, D_READ} dstate_t;
  typedef struct packed {
    logic [1:0] cs_sync;
    logic [1:0] sclk_sync;
    logic [1:0] din_sync;
    logic sclk_prev;
    dstate_t st;
    adc_link_pkg::mode_t mode;
    logic [5:0] edge_cnt;
    logic [5:0] last_edge;
    logic [5:0] cmd_sh;
    logic [2:0] chan;
    logic [5:0] osc_div;
    logic osc_lvl;
    logic [7:0] osc_cnt;
    logic [7:0] osc_end;
    logic [adc_link_pkg::RES_W-1:0] res_sh;
    logic dout;
    logic strobe;
    logic analog_on;
    logic ref_on;
    logic sample;
    logic cfg_def;
  } dev_st_t;

  // power-on state: external clock mode, all circuitry active
  localparam dev_st_t RST = '{
    cs_sync: 2'h3, st: D_IDLE, mode: adc_link_pkg::MODE_EXT_CLK,
    analog_on: 1'b1, ref_on: 1'b1, cfg_def: 1'b1, default: '0};

  dev_st_t s_q;
  dev_st_t s_d;
  logic rise;
  logic fall;
  logic cs_low;
  logic din_b;
  logic [7:0] byte_in;

  // edges are found on the second synchroniser stage only
  assign rise = s_q.sclk_sync[1] & ~s_q.sclk_prev;
  assign fall = ~s_q.sclk_sync[1] & s_q.sclk_prev;
  assign cs_low = ~s_q.cs_sync[1];
  assign din_b = s_q.din_sync[1];
  assign byte_in = {1'b1, s_q.cmd_sh, din_b};

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.cs_sync = {s_q.cs_sync[0], link.cs_n};
    s_d.sclk_sync = {s_q.sclk_sync[0], link.sclk};
    s_d.din_sync = {s_q.din_sync[0], link.din};
    s_d.sclk_prev = s_q.sclk_sync[1];
    s_d.sample = 1'b0;
    s_d.cfg_def = 1'b0;
    case (s_q.st)
      D_IDLE: begin
        // first high bit with select low opens a byte; it also drops the strobe
        if (cs_low && rise && din_b) begin
          s_d.strobe = 1'b0;
          s_d.edge_cnt = '0;
          s_d.st = D_CMD;
        end
      end
      D_CMD: begin
        // a select glitch mid-byte aborts it and leaves the mode untouched
        if (!cs_low) begin
          s_d.st = D_IDLE;
        end else if (fall) begin
          s_d.edge_cnt = s_q.edge_cnt + 6'h01;
        end else if (rise) begin
          s_d.cmd_sh = {s_q.cmd_sh[4:0], din_b};
          if (s_q.edge_cnt == adc_link_pkg::CMD_LAST) begin
            s_d.st = D_IDLE;
            if (byte_in[adc_link_pkg::TAIL_MSB:0] == adc_link_pkg::MODE_TAIL) begin
              case (adc_link_pkg::mode_t'(byte_in[adc_link_pkg::FIELD_MSB:adc_link_pkg::FIELD_LSB]))
                adc_link_pkg::MODE_RSVD3, adc_link_pkg::MODE_RSVD5: begin
                  s_d.mode = s_q.mode;
                end
                adc_link_pkg::MODE_RESET: begin
                  s_d.mode = adc_link_pkg::MODE_EXT_CLK;
                  s_d.analog_on = 1'b1;
                  s_d.ref_on = 1'b1;
                  s_d.cfg_def = 1'b1;
                end
                adc_link_pkg::MODE_PART_PD: begin
                  s_d.mode = adc_link_pkg::MODE_PART_PD;
                  s_d.analog_on = 1'b0;
                  s_d.ref_on = 1'b1;
                end
                adc_link_pkg::MODE_FULL_PD: begin
                  s_d.mode = adc_link_pkg::MODE_FULL_PD;
                  s_d.analog_on = 1'b0;
                  s_d.ref_on = 1'b0;
                end
                default: begin
                  s_d.mode = adc_link_pkg::mode_t'(byte_in[adc_link_pkg::FIELD_MSB:adc_link_pkg::FIELD_LSB]);
                  s_d.analog_on = 1'b1;
                  s_d.ref_on = 1'b1;
                end
              endcase
            end else if (s_q.analog_on) begin
              // conversion start; powered-down states ignore it
              s_d.chan = byte_in[adc_link_pkg::FIELD_MSB:adc_link_pkg::FIELD_LSB];
              s_d.st = D_ACQ;
              case (s_q.mode)
                adc_link_pkg::MODE_EXT_ACQ: s_d.last_edge = adc_link_pkg::ACQ_SAMPLE_EDGE;
                adc_link_pkg::MODE_INT_CLK: s_d.last_edge = adc_link_pkg::INT_RELEASE_EDGE;
                default: s_d.last_edge = adc_link_pkg::EXT_OUT_EDGE;
              endcase
            end
          end
        end
      end
      D_ACQ: begin
        // select must stay low until the last serial edge of this phase
        if (!cs_low) begin
          s_d.st = D_IDLE;
        end else if (fall) begin
          s_d.edge_cnt = s_q.edge_cnt + 6'h01;
          if (s_q.mode == adc_link_pkg::MODE_EXT_CLK && s_d.edge_cnt == adc_link_pkg::EXT_SAMPLE_EDGE) begin
            s_d.sample = 1'b1;
          end
          if (s_d.edge_cnt == s_q.last_edge) begin
            case (s_q.mode)
              adc_link_pkg::MODE_EXT_ACQ: begin
                s_d.sample = 1'b1;
                s_d.osc_div = '0;
                s_d.osc_lvl = 1'b1;
                s_d.osc_cnt = '0;
                s_d.osc_end = 8'(CONV_OSC);
                s_d.st = D_OSC_RUN;
              end
              adc_link_pkg::MODE_INT_CLK: begin
                s_d.osc_div = '0;
                s_d.st = D_OSC_WAIT;
              end
              default: begin
                // external clock: conversion clocked by the host, strobe stays low
                s_d.res_sh = i_conv_result;
                s_d.dout = i_conv_result[adc_link_pkg::RES_W-1];
                s_d.last_edge = adc_link_pkg::EXT_LAST_EDGE;
                s_d.st = D_READ;
              end
            endcase
          end
        end
      end
      D_OSC_WAIT: begin
        // start-up delay of the internal oscillator, shortest figure taken
        s_d.osc_div = s_q.osc_div + 6'h01;
        if (s_q.osc_div == 6'(adc_link_pkg::OSC_START_CYC - 1)) begin
          s_d.osc_div = '0;
          s_d.osc_lvl = 1'b1;
          s_d.osc_cnt = '0;
          s_d.osc_end = 8'(adc_link_pkg::INT_SAMPLE_OSC + 8'(CONV_OSC));
          s_d.st = D_OSC_RUN;
        end
      end
      D_OSC_RUN: begin
        // internal oscillator times the work; the serial pins are not looked at
        s_d.osc_div = s_q.osc_div + 6'h01;
        if (s_q.osc_div == 6'(adc_link_pkg::OSC_HALF_CYC - 1)) begin
          s_d.osc_div = '0;
          s_d.osc_lvl = ~s_q.osc_lvl;
          if (s_q.osc_lvl) begin
            s_d.osc_cnt = s_q.osc_cnt + 8'h01;
            if (s_q.mode == adc_link_pkg::MODE_INT_CLK && s_d.osc_cnt == adc_link_pkg::INT_SAMPLE_OSC) begin
              s_d.sample = 1'b1;
            end
            if (s_d.osc_cnt == s_q.osc_end) begin
              s_d.res_sh = i_conv_result;
              s_d.dout = i_conv_result[adc_link_pkg::RES_W-1];
              s_d.strobe = 1'b1;
              s_d.edge_cnt = '0;
              s_d.last_edge = adc_link_pkg::READ_EDGES;
              s_d.st = D_DONE;
            end
          end
        end
      end
      D_DONE: begin
        if (cs_low) begin
          s_d.st = D_READ;
        end
      end
      default: begin
        // result shifts on falling serial edges, MSB already on the pin
        if (!cs_low) begin
          s_d.dout = 1'b0;
          s_d.st = D_IDLE;
        end else if (fall) begin
          s_d.edge_cnt = s_q.edge_cnt + 6'h01;
          s_d.res_sh = {s_q.res_sh[adc_link_pkg::RES_W-2:0], 1'b0};
          s_d.dout = s_q.res_sh[adc_link_pkg::RES_W-2];
          if (s_d.edge_cnt == s_q.last_edge) begin
            s_d.dout = 1'b0;
            s_d.st = D_IDLE;
          end
        end
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state flops
  assign link.dout = s_q.dout;
  assign link.conversion_done_strobe = s_q.strobe;
  assign o_sample_pulse = s_q.sample;
  assign o_channel = s_q.chan;
  assign o_analog_on = s_q.analog_on;
  assign o_ref_on = s_q.ref_on;
  assign o_cfg_default = s_q.cfg_def;
  assign o_mode = s_q.mode;
endmodule

// >>> rtl/adc_host_ctrl.sv
// host end: serial master with result fifo
// ==========================================================
// result fifo with registered outputs
module adc_word_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic in_ready;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } fifo_st_t;
  localparam fifo_st_t RST = '{in_ready: 1'b1, default: '0};

  fifo_st_t f_q;
  fifo_st_t f_d;

  // wrap works for depths that are not a power of two
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // full and empty flags follow the next count, so they never lie
  always_comb begin
    f_d = f_q;
    if (i_in_valid && f_q.in_ready) begin
      f_d.mem[f_q.wr] = i_in_data;
      f_d.wr = ptr_inc(f_q.wr);
    end
    if (i_out_ready && f_q.out_valid) begin
      f_d.rd = ptr_inc(f_q.rd);
    end
    if ((i_in_valid && f_q.in_ready) && !(i_out_ready && f_q.out_valid)) begin
      f_d.cnt = f_q.cnt + (AW+1)'(1);
    end else if (!(i_in_valid && f_q.in_ready) && (i_out_ready && f_q.out_valid)) begin
      f_d.cnt = f_q.cnt - (AW+1)'(1);
    end
    f_d.in_ready = (f_d.cnt != (AW+1)'(DEPTH));
    f_d.out_valid = (f_d.cnt != '0);
    f_d.out_data = f_d.mem[f_d.rd];
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      f_q <= RST;
    end else begin
      f_q <= f_d;
    end
  end

  assign o_in_ready = f_q.in_ready;
  assign o_out_valid = f_q.out_valid;
  assign o_out_data = f_q.out_data;
endmodule

// ==========================================================
// serial master
module adc_host_ctrl #(
  parameter int unsigned SCLK_HALF = adc_link_pkg::SCLK_HALF_DEF,
  parameter int unsigned REF_WAIT_CYC = adc_link_pkg::REF_WAIT_CYC,
  parameter int unsigned FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // serial link
  adc_link_if.host link,
  // commands
  input wire logic i_cmd_valid,
  input wire logic i_cmd_is_mode,
  input wire logic [2:0] i_cmd_code,
  output logic o_mode_ready,
  output logic o_conv_ready,
  output logic o_ref_ok,
  // results
  output logic o_word_valid,
  output logic [adc_link_pkg::RES_W-1:0] o_word_data,
  input wire logic i_word_ready
);
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_CLK, H_HOLD, H_WAIT, H_PUSH} hstate_t;
  typedef struct packed {
    logic [1:0] dout_sync;
    logic [1:0] strb_sync;
    hstate_t st;
    adc_link_pkg::mode_t mode;
    logic conv;
    logic [7:0] div;
    logic sclk;
    logic cs_n;
    logic din;
    logic [5:0] edge_cnt;
    logic [5:0] n_edges;
    logic [5:0] rd_first;
    logic [7:0] tx;
    logic [adc_link_pkg::RES_W-1:0] rx;
    logic [31:0] wait_cnt;
    logic ref_ok;
    logic mode_rdy;
    logic conv_rdy;
    logic push;
  } host_st_t;
  localparam host_st_t RST = '{cs_n: 1'b1, st: H_IDLE, mode: adc_link_pkg::MODE_EXT_CLK, default: '0};

  host_st_t h_q;
  host_st_t h_d;
  logic fifo_ready;
  logic take;
  logic half;

  assign take = i_cmd_valid && (i_cmd_is_mode ? h_q.mode_rdy : h_q.conv_rdy);
  assign half = (h_q.div == 8'(SCLK_HALF - 1));

  always_comb begin
    h_d = h_q;
    h_d.dout_sync = {h_q.dout_sync[0], link.dout};
    h_d.strb_sync = {h_q.strb_sync[0], link.conversion_done_strobe};
    // reference settling after power-up and after full power-down
    if (!h_q.ref_ok) begin
      h_d.wait_cnt = h_q.wait_cnt + 32'h1;
      if (h_q.wait_cnt == 32'(REF_WAIT_CYC - 1)) begin
        h_d.ref_ok = 1'b1;
      end
    end
    case (h_q.st)
      H_IDLE: begin
        if (take && i_cmd_is_mode) begin
          // reserved codes are taken and dropped, never sent
          if (i_cmd_code != adc_link_pkg::MODE_RSVD3 && i_cmd_code != adc_link_pkg::MODE_RSVD5) begin
            h_d.tx = {1'b1, i_cmd_code, adc_link_pkg::MODE_TAIL};
            h_d.n_edges = adc_link_pkg::CMD_EDGES;
            h_d.rd_first = adc_link_pkg::NO_READ;
            h_d.conv = 1'b0;
            h_d.st = H_SETUP;
            h_d.mode = (i_cmd_code == adc_link_pkg::MODE_RESET) ? adc_link_pkg::MODE_EXT_CLK :
              adc_link_pkg::mode_t'(i_cmd_code);
            if (h_q.mode == adc_link_pkg::MODE_FULL_PD && i_cmd_code != adc_link_pkg::MODE_FULL_PD) begin
              h_d.ref_ok = 1'b0;
              h_d.wait_cnt = '0;
            end
          end
        end else if (take) begin
          h_d.tx = {1'b1, i_cmd_code, adc_link_pkg::CONV_TAIL};
          h_d.conv = 1'b1;
          h_d.st = H_SETUP;
          case (h_q.mode)
            adc_link_pkg::MODE_EXT_ACQ: begin
              h_d.n_edges = adc_link_pkg::ACQ_SAMPLE_EDGE;
              h_d.rd_first = adc_link_pkg::NO_READ;
            end
            adc_link_pkg::MODE_INT_CLK: begin
              h_d.n_edges = adc_link_pkg::INT_RELEASE_EDGE;
              h_d.rd_first = adc_link_pkg::NO_READ;
            end
            default: begin
              h_d.n_edges = adc_link_pkg::EXT_LAST_EDGE;
              h_d.rd_first = adc_link_pkg::EXT_READ_FIRST;
            end
          endcase
        end
        if (h_d.st == H_SETUP) begin
          h_d.cs_n = 1'b0;
          h_d.din = h_d.tx[adc_link_pkg::START_POS];
          h_d.div = '0;
          h_d.edge_cnt = '0;
        end
      end
      H_SETUP, H_CLK: begin
        // serial clock from a divider; data changes on falling, is read on rising
        h_d.div = h_q.div + 8'h01;
        if (half) begin
          h_d.div = '0;
          h_d.st = H_CLK;
          if (!h_q.sclk) begin
            h_d.sclk = 1'b1;
            h_d.edge_cnt = h_q.edge_cnt + 6'h01;
            if (h_d.edge_cnt >= h_q.rd_first && h_d.edge_cnt <= h_q.n_edges) begin
              h_d.rx = {h_q.rx[adc_link_pkg::RES_W-2:0], h_q.dout_sync[1]};
            end
          end else begin
            h_d.sclk = 1'b0;
            h_d.tx = {h_q.tx[6:0], 1'b0};
            h_d.din = h_q.tx[6];
            if (h_q.edge_cnt == h_q.n_edges) begin
              h_d.st = H_HOLD;
            end
          end
        end
      end
      H_HOLD: begin
        // select rises half a clock after the last falling edge
        h_d.div = h_q.div + 8'h01;
        if (half) begin
          h_d.cs_n = 1'b1;
          h_d.din = 1'b0;
          if (h_q.rd_first != adc_link_pkg::NO_READ) begin
            h_d.push = 1'b1;
            h_d.st = H_PUSH;
          end else begin
            h_d.st = h_q.conv ? H_WAIT : H_IDLE;
          end
        end
      end
      H_WAIT: begin
        // clock and data idle while the converter runs on its own clock
        if (h_q.strb_sync[1]) begin
          h_d.cs_n = 1'b0;
          h_d.div = '0;
          h_d.edge_cnt = '0;
          h_d.tx = '0;
          h_d.n_edges = adc_link_pkg::READ_EDGES;
          h_d.rd_first = adc_link_pkg::READ_FIRST;
          h_d.st = H_SETUP;
        end
      end
      default: begin
        if (fifo_ready) begin
          h_d.push = 1'b0;
          h_d.st = H_IDLE;
        end
      end
    endcase
    // readiness is registered; a full fifo holds conversions back
    h_d.mode_rdy = (h_q.st == H_IDLE) && (h_d.st == H_IDLE) && !take;
    h_d.conv_rdy = h_d.mode_rdy && h_d.ref_ok && fifo_ready && (h_d.mode != adc_link_pkg::MODE_PART_PD) &&
      (h_d.mode != adc_link_pkg::MODE_FULL_PD);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      h_q <= RST;
    end else begin
      h_q <= h_d;
    end
  end

  // result buffer between serial reader and user
  adc_word_fifo #(.WIDTH(adc_link_pkg::RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(h_q.push),
    .i_in_data(h_q.rx),
    .o_in_ready(fifo_ready),
    .o_out_valid(o_word_valid),
    .o_out_data(o_word_data),
    .i_out_ready(i_word_ready)
  );

  assign link.cs_n = h_q.cs_n;
  assign link.sclk = h_q.sclk;
  assign link.din = h_q.din;
  assign o_mode_ready = h_q.mode_rdy;
  assign o_conv_ready = h_q.conv_rdy;
  assign o_ref_ok = h_q.ref_ok;
endmodule

// >>> tb/adc_link_properties.sv
// concurrent checks on the serial link between converter end and host end
module adc_link_properties (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // link signals
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic conversion_done_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // helper: rising serial clock edges within the current frame
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic [5:0] rises_q;
  // cleared while deselected so every frame counts from zero
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rises_q <= 6'h00;
    end else if (cs_n) begin
      rises_q <= 6'h00;
    end else if ($rose(sclk)) begin
      rises_q <= rises_q + 6'h01;
    end
  end
  // ==========================================================
  // link properties
  idle_clock_low_a: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  din_setup_low_a: assert property ($changed(din) && !cs_n && !$fell(cs_n) |-> !sclk)
    else $error("data in changed with clock high");
  dout_falling_edge_a: assert property ($changed(dout) |-> !sclk)
    else $error("data out changed with clock high");
  strobe_fall_start_a: assert property ($fell(conversion_done_strobe) |-> !cs_n && sclk)
    else $error("strobe fell outside a start bit");
  strobe_rise_idle_a: assert property ($rose(conversion_done_strobe) |-> cs_n && !sclk)
    else $error("strobe rose during a frame");
  strobe_hold_a: assert property (conversion_done_strobe && cs_n |=> conversion_done_strobe)
    else $error("strobe dropped while deselected");
  clock_high_width_a: assert property ($rose(sclk) |-> sclk[*8])
    else $error("serial clock high phase too short");
  frame_whole_bytes_a: assert property ($rose(cs_n) |-> rises_q >= 6'h08 && rises_q[2:0] == 3'h0)
    else $error("frame not a whole number of bytes");
  // main scenarios
  cover property ($rose(conversion_done_strobe));
  cover property ($fell(conversion_done_strobe));
  cover property ($rose(cs_n) && rises_q == 6'h20);
endmodule

// >>> tb/adc_serial_mode_control_test.sv
// self-checking bench joining the converter end and the host end
module adc_serial_mode_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_is_mode = 1'b0;
  logic [2:0] cmd_code = 3'h0;
  logic word_ready = 1'b0;
  logic [15:0] result = 16'h0000;
  logic mode_rdy, conv_rdy, ref_ok, analog_on, ref_on, cfg_def, samp, wvalid;
  logic [2:0] chan, mode;
  logic [15:0] wdata;
  logic [15:0] exp_q[$];
  int n_errors = 0;
  int cmp_count = 0;
  int n_samp = 0;
  int n_strb = 0;
  int n_cfg = 0;
  int n_ref = 0;
  logic ref_p = 1'b0;
  // mode codes in order: reserved ones and every power-state exit included
  logic [2:0] seq [12] = '{3'h6, 3'h3, 3'h7, 3'h5, 3'h6, 3'h2, 3'h7, 3'h4, 3'h1, 3'h0, 3'h6, 3'h4};
  logic [2:0] cm [4] = '{3'h0, 3'h1, 3'h2, 3'h0};
  `define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
  always #2.5 clk = ~clk;
  adc_link_if lnk ();
  adc_mode_ctrl #(.CONV_OSC(4)) u_adc_mode_ctrl (.i_ref_clk(clk), .i_rst_n(rst_n), .link(lnk.dev),
    .i_conv_result(result), .o_sample_pulse(samp), .o_channel(chan), .o_analog_on(analog_on),
    .o_ref_on(ref_on), .o_cfg_default(cfg_def), .o_mode(mode));
  adc_host_ctrl #(.REF_WAIT_CYC(50)) u_adc_host_ctrl (.i_ref_clk(clk), .i_rst_n(rst_n), .link(lnk.host),
    .i_cmd_valid(cmd_valid), .i_cmd_is_mode(cmd_is_mode), .i_cmd_code(cmd_code), .o_mode_ready(mode_rdy),
    .o_conv_ready(conv_rdy), .o_ref_ok(ref_ok), .o_word_valid(wvalid), .o_word_data(wdata),
    .i_word_ready(word_ready));
  adc_link_properties u_adc_link_properties (.i_ref_clk(clk), .i_rst_n(rst_n), .cs_n(lnk.cs_n),
    .sclk(lnk.sclk), .din(lnk.din), .dout(lnk.dout), .conversion_done_strobe(lnk.conversion_done_strobe));
  // event counts on the falling edge, half a cycle away from the edge that moves them
  always @(negedge clk) begin
    if (samp === 1'b1) n_samp++;
    if (lnk.conversion_done_strobe === 1'b1) n_strb++;
    if (cfg_def === 1'b1) n_cfg++;
    if (ref_p === 1'b1 && ref_ok === 1'b0) n_ref++;
    ref_p = ref_ok;
  end
  // ==========================================================
  // expectations and drivers
  function automatic logic [2:0] nxt(input logic [2:0] cur, input logic [2:0] c);
    // reserved codes are dropped, the reset code returns to external clock
    if (c == 3'h3 || c == 3'h5) return cur;
    return (c == 3'h4) ? 3'h0 : c;
  endfunction
  // waits for idle before and after, so takes are never closer than allowed
  task automatic send(input logic is_m, input logic [2:0] c);
    for (int k = 0; k < 4000 && (is_m ? mode_rdy : conv_rdy) !== 1'b1; k++) @(negedge clk);
    `CHK("ready", 1'b1, (is_m ? mode_rdy : conv_rdy))
    cmd_valid = 1'b1;
    cmd_is_mode = is_m;
    cmd_code = c;
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (3) @(negedge clk);
    for (int k = 0; k < 9000 && mode_rdy !== 1'b1; k++) @(negedge clk);
    `CHK("idle", 1'b1, mode_rdy)
    repeat (8) @(negedge clk);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [2:0] cur;
    logic [2:0] c;
    logic [15:0] w;
    void'($urandom(49));
    repeat (16) @(negedge clk);
    `CHK("cfg_def", 1'b1, cfg_def)
    rst_n = 1'b1;
    @(negedge clk);
    `CHK("mode", 3'h0, mode)
    `CHK("analog", 1'b1, analog_on)
    `CHK("ref_ok", 1'b0, ref_ok)
    repeat (2) @(negedge clk);
    n_cfg = 0;
    cur = 3'h0;
    // every code, reserved ones and power-state exits included
    foreach (seq[i]) begin
      send(1'b1, seq[i]);
      cur = nxt(cur, seq[i]);
      `CHK("mode", cur, mode)
      `CHK("analog", !(cur == 3'h6 || cur == 3'h7), analog_on)
      `CHK("ref", cur != 3'h7, ref_on)
      if (cur >= 3'h6) `CHK("conv_rdy", 1'b0, conv_rdy)
      else `CHK("conv_rdy", 1'b1, conv_rdy)
    end
    `CHK("cfg_pulses", 2, n_cfg)
    `CHK("ref_drops", 2, n_ref)
    // four conversions fill the fifo while the drain side stalls
    foreach (cm[i]) begin
      send(1'b1, cm[i]);
      result = 16'($urandom());
      c = 3'($urandom_range(7));
      exp_q.push_back(result);
      n_samp = 0;
      n_strb = 0;
      send(1'b0, c);
      `CHK("channel", c, chan)
      `CHK("samples", 1, n_samp)
      `CHK("strobe", cm[i] != 3'h0, n_strb > 0)
    end
    repeat (20) @(negedge clk);
    `CHK("full", 1'b0, conv_rdy)
    // the head word is looked at before the rising edge that pops it
    word_ready = 1'b1;
    for (int k = 0; k < 200 && exp_q.size() > 0; k++) begin
      if (wvalid === 1'b1) begin
        w = exp_q.pop_front();
        `CHK("word", w, wdata)
      end
      @(negedge clk);
    end
    `CHK("drained", 0, exp_q.size())
    end_of_test();
  end
  // watchdog: the sequence needs about 8000 cycles
  initial begin
    #200us;
    n_errors++;
    end_of_test();
  end
endmodule
